// ===== core/can_irq_err_defs.svh
`ifndef CAN_IRQ_ERR_DEFS_SVH
`define CAN_IRQ_ERR_DEFS_SVH

// special function register addresses
`define ADDR_TX_ERR 8'hE6
`define ADDR_RX_ERR 8'hE7
`define ADDR_IRQ_EN 8'hE8
`define RDATA_UNMAPPED 8'h00
`define IRQ_EN_RESET 8'h00
`define IRQ_EN_CAN1_BIT 5
`define IRQ_EN_BUSACT_BIT 7

// interrupt source codes
`define CODE_NONE 8'h00
`define CODE_STATUS 8'h01
`define CODE_MC15 8'h02
`define CODE_MC1 8'h03
`define MC_LAST_LOW 14
`define MC_RX_ONLY 15

// error counter thresholds and steps
`define CNT_ZERO 9'h000
`define CNT_WARN_LIM 9'h060
`define CNT_PASSIVE_LIM 9'h080
`define CNT_BUSOFF_LIM 9'h0FF
`define CNT_TX_MAX 9'h100
`define CNT_RX_MAX 9'h0FF
`define TX_ERR_STEP 4'h8
`define RX_ERR_STEP 4'h1
`define CNT8_FULL 8'hFF

`endif

// ===== core/can_irq_err_pkg.sv
package can_irq_err_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sfr_req_t;

	typedef enum logic [1:0] {
		MODE_ACTIVE,
		MODE_WARNING,
		MODE_PASSIVE,
		MODE_BUS_OFF
	} err_mode_t;

endpackage : can_irq_err_pkg

// ===== core/irq_source_select.sv
`timescale 1ns/10ps
`default_nettype none
`include "can_irq_err_defs.svh"

module irq_source_select (
	// pending sources
	input wire logic status_pend,
	input wire logic [15:1] flags,
	// displayed code
	input wire logic [7:0] cur_code,
	output logic [7:0] next_code
);

	function automatic logic [7:0] encode(input logic st,
		input logic [15:1] f);
		logic [7:0] c;
		c = `CODE_NONE;
		for (int k = `MC_LAST_LOW; k >= 1; k--) begin
			if (f[k]) begin
				c = 8'(`CODE_MC1 + k - 1);
			end
		end
		if (f[`MC_RX_ONLY]) begin
			c = `CODE_MC15;
		end
		if (st) begin
			c = `CODE_STATUS;
		end
		return c;
	endfunction : encode

	function automatic logic still_active(input logic [7:0] c,
		input logic st, input logic [15:1] f);
		logic a;
		a = 1'b0;
		if (c == `CODE_STATUS) begin
			a = st;
		end else if (c == `CODE_MC15) begin
			a = f[`MC_RX_ONLY];
		end
		for (int k = 1; k <= `MC_LAST_LOW; k++) begin
			if (c == 8'(`CODE_MC1 + k - 1)) begin
				a = f[k];
			end
		end
		return a;
	endfunction : still_active

	wire logic [7:0] best_code;
	wire logic hold_cur;

	assign best_code = encode(status_pend, flags); // RULE1 RULE4
	assign hold_cur = (cur_code != `CODE_NONE)
		&& still_active(cur_code, status_pend, flags); // RULE3
	// a removed source falls through to the best one still pending
	assign next_code = hold_cur ? cur_code : best_code; // RULE7

endmodule : irq_source_select
`default_nettype wire

// ===== core/fault_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "can_irq_err_defs.svh"

module fault_counter (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic clr,
	input wire logic load,
	input wire logic [7:0] load_val,
	input wire logic up,
	input wire logic [3:0] up_step,
	input wire logic down,
	input wire logic [8:0] cnt_max,
	// count
	output logic [8:0] cnt
);

	logic [8:0] cnt_r;
	logic [8:0] cnt_nxt;
	wire logic [9:0] sum;

	assign sum = {1'b0, cnt_r} + {6'h00, up_step};

	// errors outweigh a success reported in the same cycle
	always_comb begin
		cnt_nxt = cnt_r;
		if (clr) begin
			cnt_nxt = `CNT_ZERO;
		end else if (load) begin
			cnt_nxt = {1'b0, load_val};
		end else if (up) begin
			cnt_nxt = (sum > {1'b0, cnt_max}) ? cnt_max : sum[8:0];
		end else if (down && cnt_r != `CNT_ZERO) begin
			cnt_nxt = cnt_r - 9'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r <= `CNT_ZERO;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign cnt = cnt_r;

endmodule : fault_counter
`default_nettype wire

// ===== core/can_irq_err_ctrl.sv
// Behaviour
// [RULE1] code 00h none, 01h status change, 02h center 15, 03h-10h centers 1-14
// [RULE2] the source code returns to 00h on reset
// [RULE3] a displayed non-zero code stays until its own source goes away
// [RULE4] simultaneous sources with nothing shown display the higher priority
// [RULE5] controller request is high exactly while the code is non-zero
// [RULE6] status read or flag clear acknowledges the displayed source
// [RULE7] after removal the code shows the best remaining source or 00h
// [RULE8] status source needs change, matching enable and pending state
// [RULE9] a center source is active while its request flag is set
// [RULE10] transmit error count is readable as an 8-bit register
// [RULE11] transmit count writes need init mode set and bus-off clear
// [RULE12] accepted transmit count write loads both counters together
// [RULE13] writing zero to the transmit count clears error-count-exceeded
// [RULE14] both counters clear on hardware reset and controller soft reset
// [RULE15] mode active, warning from 96, passive from 128, bus-off above 255
// [RULE16] receive error count is readable, written only via transmit count
// [RULE17] enable bit 5 gates the controller interrupt to the processor
// [RULE18] enable bit 7 gates the shared bus-activity interrupt
// [RULE19] any status register read clears a pending status change
// [RULE20] request flag sets on stored receive or sent transmit if enabled
// [RULE21] counters follow fault confinement steps, wide enough for bus-off
`timescale 1ns/10ps
`default_nettype none
`include "can_irq_err_defs.svh"

module can_irq_err_ctrl
	import can_irq_err_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// special function register access
	input wire sfr_req_t SFR_REQ,
	output logic [7:0] SFR_RDATA,
	// controller status side
	input wire logic STATUS_CHANGE,
	input wire logic STATUS_CHANGE_IS_ERROR,
	input wire logic ERROR_IRQ_ENABLE,
	input wire logic STATUS_IRQ_ENABLE,
	input wire logic STATUS_READ,
	input wire logic SOFTWARE_INIT_MODE,
	input wire logic CONTROLLER_SOFT_RESET,
	output logic ERROR_COUNT_EXCEEDED_CLR,
	// message centers 1 to 15
	input wire logic [15:1] RX_STORED,
	input wire logic [15:1] TX_DONE,
	input wire logic [15:1] RX_DONE_IRQ_ENABLE,
	input wire logic [15:1] TX_DONE_IRQ_ENABLE,
	input wire logic [15:1] FLAG_CLEAR,
	output logic [15:1] CENTER_REQUEST_FLAG,
	// bus error events
	input wire logic TX_ERROR,
	input wire logic TX_SUCCESS,
	input wire logic RX_ERROR,
	input wire logic RX_SUCCESS,
	// bus activity
	input wire logic BUS_ACTIVITY,
	// interrupt and status outputs
	output logic [7:0] IRQ_SOURCE_CODE,
	output logic CAN1_SOURCE_ACTIVE,
	output logic CAN1_IRQ,
	output logic BUS_ACTIVITY_IRQ,
	output logic [7:0] EXT_IRQ_ENABLES,
	output err_mode_t ERROR_MODE,
	output logic BUS_OFF
);

	////////////////////////////////////////////////////////////////////
	// register decode

	wire logic sel_tx;
	wire logic sel_rx;
	wire logic sel_en;
	wire logic tec_wr;
	wire logic tec_wr_ok;
	wire logic soft_clr;

	assign sel_tx = (SFR_REQ.addr == `ADDR_TX_ERR);
	assign sel_rx = (SFR_REQ.addr == `ADDR_RX_ERR);
	assign sel_en = (SFR_REQ.addr == `ADDR_IRQ_EN);
	assign tec_wr = SFR_REQ.wr && sel_tx;
	assign soft_clr = CONTROLLER_SOFT_RESET;

	////////////////////////////////////////////////////////////////////
	// error counters

	logic [8:0] tec;
	logic [8:0] rec;
	wire logic bus_off;
	wire logic [8:0] worst;

	function automatic logic [7:0] sat8(input logic [8:0] v);
		return v[8] ? `CNT8_FULL : v[7:0];
	endfunction : sat8

	assign bus_off = (tec > `CNT_BUSOFF_LIM); // RULE15
	// an ignored write leaves both counters untouched
	assign tec_wr_ok = tec_wr && SOFTWARE_INIT_MODE && !bus_off; // RULE11
	assign worst = (tec > rec) ? tec : rec;

	fault_counter u_tx_count (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.clr(soft_clr), // RULE14
		.load(tec_wr_ok), // RULE12
		.load_val(SFR_REQ.wdata),
		.up(TX_ERROR), // RULE21
		.up_step(`TX_ERR_STEP),
		.down(TX_SUCCESS),
		.cnt_max(`CNT_TX_MAX),
		.cnt(tec)
	);

	fault_counter u_rx_count (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.clr(soft_clr), // RULE14
		.load(tec_wr_ok), // RULE12 RULE16
		.load_val(SFR_REQ.wdata),
		.up(RX_ERROR), // RULE21
		.up_step(`RX_ERR_STEP),
		.down(RX_SUCCESS),
		.cnt_max(`CNT_RX_MAX),
		.cnt(rec)
	);

	err_mode_t mode_r;
	err_mode_t mode_nxt;
	logic error_count_exceeded_clr_r;

	always_comb begin
		if (bus_off) begin
			mode_nxt = MODE_BUS_OFF;
		end else if (worst >= `CNT_PASSIVE_LIM) begin
			mode_nxt = MODE_PASSIVE;
		end else if (worst >= `CNT_WARN_LIM) begin
			mode_nxt = MODE_WARNING;
		end else begin
			mode_nxt = MODE_ACTIVE; // RULE15
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			mode_r <= MODE_ACTIVE;
			error_count_exceeded_clr_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			error_count_exceeded_clr_r <= tec_wr_ok
				&& (SFR_REQ.wdata == `CODE_NONE); // RULE13
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt enables and read data

	logic [7:0] irq_en_r;
	logic [7:0] rdata_r;
	wire logic [7:0] rd_mux;

	assign rd_mux = sel_tx ? sat8(tec) // RULE10
		: sel_rx ? sat8(rec) // RULE16
		: sel_en ? irq_en_r
		: `RDATA_UNMAPPED;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			irq_en_r <= `IRQ_EN_RESET;
			rdata_r <= `RDATA_UNMAPPED;
		end else begin
			if (SFR_REQ.wr && sel_en) begin
				irq_en_r <= SFR_REQ.wdata;
			end
			if (SFR_REQ.rd) begin
				rdata_r <= rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt sources

	logic st_pend_r;
	logic [15:1] flag_r;
	wire logic st_set;
	wire logic [15:1] flag_set;
	wire logic [15:1] tx_en_eff;

	// the enable that matches the kind of change must be on
	assign st_set = STATUS_CHANGE && (STATUS_CHANGE_IS_ERROR
		? ERROR_IRQ_ENABLE : STATUS_IRQ_ENABLE); // RULE8
	// center 15 only receives, its transmit enable means nothing
	assign tx_en_eff = {1'b0, TX_DONE_IRQ_ENABLE[14:1]};
	assign flag_set = (RX_STORED & RX_DONE_IRQ_ENABLE)
		| (TX_DONE & tx_en_eff); // RULE20

	// a new event in a flag clear or status read cycle survives it, a soft reset does not
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || soft_clr) begin
			st_pend_r <= 1'b0;
			flag_r <= '0;
		end else begin
			st_pend_r <= st_set || (st_pend_r && !STATUS_READ); // RULE19
			flag_r <= flag_set | (flag_r & ~FLAG_CLEAR); // RULE6
		end
	end

	////////////////////////////////////////////////////////////////////
	// displayed source code

	logic [7:0] code_r;
	logic [7:0] code_nxt;

	irq_source_select u_select (
		.status_pend(st_pend_r), // RULE8
		.flags(flag_r), // RULE9
		.cur_code(code_r),
		.next_code(code_nxt)
	);

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			code_r <= `CODE_NONE; // RULE2
		end else begin
			code_r <= code_nxt; // RULE3 RULE7
		end
	end

	wire logic src_active;

	assign src_active = (code_r != `CODE_NONE); // RULE5
	assign CAN1_SOURCE_ACTIVE = src_active;
	assign CAN1_IRQ = src_active && irq_en_r[`IRQ_EN_CAN1_BIT]; // RULE17
	assign BUS_ACTIVITY_IRQ = BUS_ACTIVITY
		&& irq_en_r[`IRQ_EN_BUSACT_BIT]; // RULE18

	////////////////////////////////////////////////////////////////////
	// outputs

	assign SFR_RDATA = rdata_r;
	assign ERROR_COUNT_EXCEEDED_CLR = error_count_exceeded_clr_r;
	assign CENTER_REQUEST_FLAG = flag_r;
	assign IRQ_SOURCE_CODE = code_r;
	assign EXT_IRQ_ENABLES = irq_en_r;
	assign ERROR_MODE = mode_r;
	assign BUS_OFF = bus_off;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);

	chk_code_reset: assert property ( // RULE2
		@(posedge CLK_SYS) disable iff (1'b0)
		!RST_N |=> code_r == `CODE_NONE)
		else $error("source code not cleared by reset");

	chk_code_hold: assert property ( // RULE3
		code_r == `CODE_STATUS && st_pend_r && !STATUS_READ
		&& !soft_clr |=> code_r == `CODE_STATUS)
		else $error("displayed status code replaced while pending");

	chk_mc_hold: assert property ( // RULE3
		code_r == `CODE_MC1 + 8'h01 && flag_r[2] && !FLAG_CLEAR[2]
		&& !soft_clr && st_set |=> code_r == `CODE_MC1 + 8'h01)
		else $error("center code pre-empted by status change");

	chk_simul_prio: assert property ( // RULE4
		code_r == `CODE_NONE && st_pend_r && flag_r[1]
		|=> code_r == `CODE_STATUS)
		else $error("lower priority source shown first");

	chk_mc15_prio: assert property ( // RULE1
		code_r == `CODE_NONE && !st_pend_r && flag_r[15]
		&& flag_r[1] |=> code_r == `CODE_MC15)
		else $error("center 15 not above center 1");

	chk_req_level: assert property ( // RULE5
		CAN1_IRQ == (IRQ_SOURCE_CODE != `CODE_NONE
		&& EXT_IRQ_ENABLES[`IRQ_EN_CAN1_BIT]))
		else $error("request not tied to non-zero code");

	chk_status_ack: assert property ( // RULE19
		code_r == `CODE_STATUS && STATUS_READ && !st_set
		|=> ##1 code_r != `CODE_STATUS)
		else $error("status read did not release the code");

	chk_flag_set: assert property ( // RULE20
		RX_STORED[3] && RX_DONE_IRQ_ENABLE[3] && !soft_clr
		|=> CENTER_REQUEST_FLAG[3] ##1 code_r != `CODE_NONE)
		else $error("enabled reception did not raise request");

	chk_tec_ignore: assert property ( // RULE11
		tec_wr && !SOFTWARE_INIT_MODE && !soft_clr && !TX_ERROR
		&& !TX_SUCCESS |=> $stable(tec))
		else $error("transmit count written outside init mode");

	chk_load_both: assert property ( // RULE12
		tec_wr_ok && !soft_clr
		|=> tec == {1'b0, $past(SFR_REQ.wdata)}
		&& rec == {1'b0, $past(SFR_REQ.wdata)})
		else $error("counters not loaded together");

	chk_error_count_exceeded_clear: assert property ( // RULE13
		tec_wr_ok && SFR_REQ.wdata == `CODE_NONE
		|=> ERROR_COUNT_EXCEEDED_CLR ##1 !ERROR_COUNT_EXCEEDED_CLR
		|| $past(tec_wr_ok))
		else $error("zero write did not pulse exceeded clear");

	chk_soft_clear: assert property ( // RULE14
		soft_clr |=> tec == `CNT_ZERO && rec == `CNT_ZERO
		&& CENTER_REQUEST_FLAG == '0)
		else $error("soft reset left counters or flags");

	chk_busoff: assert property ( // RULE15
		bus_off |=> ERROR_MODE == MODE_BUS_OFF || $past(soft_clr))
		else $error("bus-off not reflected in mode");

	chk_bus_act: assert property ( // RULE18
		BUS_ACTIVITY_IRQ |-> BUS_ACTIVITY
		&& EXT_IRQ_ENABLES[`IRQ_EN_BUSACT_BIT])
		else $error("bus activity interrupt not gated");

	cov_status_then_mc: cover property (
		code_r == `CODE_STATUS ##[1:20] code_r == `CODE_MC1);
	cov_tec_load: cover property (tec_wr_ok);
	cov_bus_off: cover property (MODE_PASSIVE == mode_r
		##[1:40] bus_off);
	cov_flag_race: cover property (|(flag_set & FLAG_CLEAR));

endmodule : can_irq_err_ctrl
`default_nettype wire

// ===== test/tb_can_irq_err_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module tb_can_irq_err_ctrl import can_irq_err_pkg::*;;

logic clk, rst_n, sc, sc_err, err_en, st_en, st_rd, init, srst;
logic tx_err, tx_ok, rx_err, rx_ok, bus_act;
logic ece_clr, src_act, irq, ba_irq, bus_off;
logic [15:1] rx_st, tx_dn, rx_en, tx_en, f_clr, flags;
logic [7:0] rdata, code, ext_en, rd_v;
sfr_req_t req;
err_mode_t mode;
int fails, samples_checked;

can_irq_err_ctrl i_can_irq_err_ctrl (
	.CLK_SYS(clk), .RST_N(rst_n), .SFR_REQ(req), .SFR_RDATA(rdata),
	.STATUS_CHANGE(sc), .STATUS_CHANGE_IS_ERROR(sc_err),
	.ERROR_IRQ_ENABLE(err_en), .STATUS_IRQ_ENABLE(st_en),
	.STATUS_READ(st_rd), .SOFTWARE_INIT_MODE(init),
	.CONTROLLER_SOFT_RESET(srst), .ERROR_COUNT_EXCEEDED_CLR(ece_clr),
	.RX_STORED(rx_st), .TX_DONE(tx_dn), .RX_DONE_IRQ_ENABLE(rx_en),
	.TX_DONE_IRQ_ENABLE(tx_en), .FLAG_CLEAR(f_clr),
	.CENTER_REQUEST_FLAG(flags), .TX_ERROR(tx_err), .TX_SUCCESS(tx_ok),
	.RX_ERROR(rx_err), .RX_SUCCESS(rx_ok), .BUS_ACTIVITY(bus_act),
	.IRQ_SOURCE_CODE(code), .CAN1_SOURCE_ACTIVE(src_act), .CAN1_IRQ(irq),
	.BUS_ACTIVITY_IRQ(ba_irq), .EXT_IRQ_ENABLES(ext_en),
	.ERROR_MODE(mode), .BUS_OFF(bus_off)
);

always #2.5 clk = ~clk;

////////////////////////////////////////////////////////////////////////////
task end_of_test;
	$display("checks=%0d fails=%0d", samples_checked, fails);
	if (fails == 0 && samples_checked > 0) begin
		$display("SIMULATION PASSED");
	end else begin
		$display("SIMULATION FAILED");
	end
	$finish;
endtask : end_of_test

task check(input logic [8:0] seen, input logic [8:0] exp);
	samples_checked++;
	if (seen !== exp) begin
		fails++;
		$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
	end
endtask : check

function logic [15:1] onehot(input int k);
	return 15'(1) << (k - 1);
endfunction : onehot

// read data lands at the same edge that samples rd
task sfr(input logic [7:0] a, input logic [7:0] d, input logic w);
	@(posedge clk);
	req <= '{addr: a, wdata: d, wr: w, rd: !w};
	@(posedge clk);
	req <= '0;
	#1;
	rd_v = rdata;
endtask : sfr

task rdchk(input logic [7:0] a, input logic [7:0] exp);
	sfr(a, 8'h00, 1'b0);
	check(rd_v, exp);
endtask : rdchk

task pulse(input logic [15:1] m, input logic tx);
	@(posedge clk);
	if (tx) tx_dn <= m;
	else rx_st <= m;
	@(posedge clk);
	tx_dn <= '0;
	rx_st <= '0;
endtask : pulse

task clr_flag(input int k);
	@(posedge clk);
	f_clr <= onehot(k);
	@(posedge clk);
	f_clr <= '0;
endtask : clr_flag

task strobe(input int w);
	@(posedge clk);
	case (w)
		0: sc <= 1'b1;
		1: st_rd <= 1'b1;
		2: tx_err <= 1'b1;
		3: rx_err <= 1'b1;
		4: tx_ok <= 1'b1;
		5: srst <= 1'b1;
		default: rx_ok <= 1'b1;
	endcase
	@(posedge clk);
	{sc, st_rd, tx_err, rx_err, tx_ok, rx_ok, srst} <= '0;
endtask : strobe

task wait_code(input logic [7:0] exp);
	int n;
	n = 0;
	// step off the edge so the code is never read while it is launched
	#1;
	while (code !== exp && n < 8) begin
		@(posedge clk);
		#1;
		n++;
	end
	check(code, exp);
	if (code !== exp) end_of_test;
endtask : wait_code

////////////////////////////////////////////////////////////////////////////
task t_reset;
	check(code, 8'h00);
	rdchk(8'hE6, 8'h00);
	rdchk(8'hE7, 8'h00);
	rdchk(8'hE8, 8'h00);
	rdchk(8'hE9, 8'h00);
endtask : t_reset

task t_table;
	for (int k = 1; k <= 15; k++) begin
		pulse(onehot(k), 1'b0);
		wait_code((k == 15) ? 8'h02 : 8'(8'h02 + k));
		check(flags[k], 1'b1);
		clr_flag(k);
		wait_code(8'h00);
	end
	pulse(onehot(3), 1'b1);
	wait_code(8'h05);
	clr_flag(3);
	wait_code(8'h00);
	// center 4 has no transmit enable, center 15 is receive only
	pulse(onehot(4) | onehot(15), 1'b1);
	repeat (4) @(posedge clk);
	#1;
	check(code, 8'h00);
	// center 15 outranks center 1 when both arrive together
	pulse(onehot(1) | onehot(15), 1'b0);
	wait_code(8'h02);
	clr_flag(15);
	wait_code(8'h03);
	clr_flag(1);
	wait_code(8'h00);
endtask : t_table

task t_hold;
	pulse(onehot(2) | onehot(14), 1'b0);
	wait_code(8'h04);
	strobe(0);
	repeat (3) @(posedge clk);
	#1;
	check(code, 8'h04);
	check(src_act, 1'b1);
	check(irq, 1'b0);
	sfr(8'hE8, 8'h20, 1'b1);
	check(irq, 1'b1);
	clr_flag(2);
	wait_code(8'h01);
	strobe(1);
	wait_code(8'h10);
	clr_flag(14);
	wait_code(8'h00);
	check(irq, 1'b0);
	@(posedge clk);
	st_en <= 1'b0;
	strobe(0);
	repeat (4) @(posedge clk);
	#1;
	check(code, 8'h00);
	@(posedge clk);
	sc_err <= 1'b1;
	strobe(0);
	wait_code(8'h01);
	strobe(1);
	wait_code(8'h00);
	// status change and center 1 in the same cycle
	@(posedge clk);
	sc <= 1'b1;
	rx_st <= onehot(1);
	@(posedge clk);
	sc <= 1'b0;
	rx_st <= '0;
	wait_code(8'h01);
	strobe(1);
	wait_code(8'h03);
	clr_flag(1);
	wait_code(8'h00);
	sfr(8'hE8, 8'h00, 1'b1);
endtask : t_hold

task t_busact;
	@(posedge clk);
	bus_act <= 1'b1;
	sfr(8'hE8, 8'h80, 1'b1);
	check(ba_irq, 1'b1);
	check(ext_en, 8'h80);
	rdchk(8'hE8, 8'h80);
	sfr(8'hE8, 8'h00, 1'b1);
	check(ba_irq, 1'b0);
endtask : t_busact

task t_count;
	sfr(8'hE6, 8'h33, 1'b1);
	rdchk(8'hE6, 8'h00);
	@(posedge clk);
	init <= 1'b1;
	sfr(8'hE6, 8'h5F, 1'b1);
	check(ece_clr, 1'b0);
	rdchk(8'hE7, 8'h5F);
	check(mode, MODE_ACTIVE);
	strobe(3);
	rdchk(8'hE7, 8'h60);
	check(mode, MODE_WARNING);
	sfr(8'hE7, 8'h11, 1'b1);
	rdchk(8'hE7, 8'h60);
	strobe(6);
	rdchk(8'hE7, 8'h5F);
	sfr(8'hE6, 8'h7F, 1'b1);
	strobe(2);
	rdchk(8'hE6, 8'h87);
	check(mode, MODE_PASSIVE);
	strobe(4);
	rdchk(8'hE6, 8'h86);
	sfr(8'hE6, 8'h00, 1'b1);
	check(ece_clr, 1'b1);
	@(posedge clk);
	#1;
	check(ece_clr, 1'b0);
	sfr(8'hE6, 8'hF8, 1'b1);
	strobe(2);
	rdchk(8'hE6, 8'hFF);
	check(bus_off, 1'b1);
	check(mode, MODE_BUS_OFF);
	sfr(8'hE6, 8'h10, 1'b1);
	rdchk(8'hE7, 8'hF8);
	strobe(5);
	rdchk(8'hE6, 8'h00);
	rdchk(8'hE7, 8'h00);
	check(bus_off, 1'b0);
	check(mode, MODE_ACTIVE);
endtask : t_count

task t_midreset;
	sfr(8'hE8, 8'hA0, 1'b1);
	pulse(onehot(5), 1'b0);
	wait_code(8'h07);
	check(irq, 1'b1);
	check(ba_irq, 1'b1);
	@(posedge clk);
	rst_n <= 1'b0;
	@(posedge clk);
	rst_n <= 1'b1;
	#1;
	check(code, 8'h00);
	check(|flags, 1'b0);
	check(ext_en, 8'h00);
	check(irq, 1'b0);
	check(ba_irq, 1'b0);
	// first event straight after release, enables are back to zero
	pulse(onehot(5), 1'b0);
	wait_code(8'h07);
	check(src_act, 1'b1);
	check(irq, 1'b0);
	clr_flag(5);
	wait_code(8'h00);
endtask : t_midreset

////////////////////////////////////////////////////////////////////////////
initial begin
	clk = 1'b0;
	rst_n = 1'b0;
	req = '0;
	{sc, sc_err, st_rd, init, srst, tx_err, tx_ok, rx_err, rx_ok} = '0;
	{err_en, st_en} = 2'b11;
	bus_act = 1'b0;
	{rx_st, tx_dn, f_clr} = '0;
	rx_en = '1;
	tx_en = onehot(3) | onehot(15);
	fails = 0;
	samples_checked = 0;
	repeat (3) @(posedge clk);
	rst_n <= 1'b1;
	@(posedge clk);
	#1;
	t_reset();
	t_table();
	t_hold();
	t_busact();
	t_count();
	t_midreset();
	end_of_test();
end

endmodule : tb_can_irq_err_ctrl

`default_nettype wire
